// file: test/save_store_model.sv
// Storage model that takes save records and can be told to stall
`timescale 1ns/10ps
module save_store_model
  import video_overlay_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     stall,
  input  wire logic     saveValid,
  input  wire save_type saveData,
  output logic          saveReady,
  output save_type      last,
  output int            count
);
  // A stall leaves the record waiting at the head of the buffer
  assign saveReady = !stall;
  // Keep each record at the edge that takes it
  always @(posedge mclk) begin
    if (saveValid && saveReady) begin
      last <= saveData;
      count <= count + 1;
    end
  end
endmodule

// file: test/test_video_overlay_control.sv
// Directed bench for the overlay control block
`timescale 1ns/10ps
module test_video_overlay_control;
  import video_overlay_pkg::*;
  logic                mclk = 0, rst_n = 0, cmdValid = 0, fieldStart = 0, stall = 0;
  logic                blackOutputOption = 0, pixelValid = 0, sampleValid = 0;
  logic                cmdReady, saveReady, pixelOutValid, saveValid, logoVisible;
  logic [1:0]          pixelComp = 0, sampleSel = 1;
  logic [2:0]          sampleGroup = 1, emphasisBits;
  logic [9:0]          pixelData = 0, pixelOut, blackLuma;
  logic [23:0]         sampleData = 24'hFF_FFFF, sampleOut;
  logic signed [11:0]  scrollH, scrollV;
  cmd_type             cmd = '0;
  settings_type        settings;
  save_type            saveData, last;
  int                  count, bad_count, checks, cyc, hid;

  video_overlay_control #(.BLINK_SHORT(8), .BLINK_LONG(16)) i_video_overlay_control (
    .mclk, .rst_n, .cmd, .cmdValid, .cmdReady, .blackOutputOption, .fieldStart, .pixelValid,
    .pixelComp, .pixelData, .sampleValid, .sampleSel, .sampleGroup, .sampleData, .saveReady,
    .settings, .blackFitted(), .logoVisible, .textVisible(), .circleVisible(), .scrollH,
    .scrollV, .pixelOutValid, .pixelOut, .blackLuma, .sampleOutValid(), .sampleOut,
    .emphasisBits, .alignmentBits(), .saveData, .saveValid);
  save_store_model i_save_store_model (.mclk, .stall, .saveValid, .saveData, .saveReady,
    .last, .count);

  // Clock and a hang limit well beyond the hundred or so cycles the tests need
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 3000) begin
    bad_count++;
    report_and_stop();
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Readiness is read at the falling edge so the taking edge is known in advance
  task automatic send(input op_type op, input logic [1:0] sel, input logic [3:0] idx,
                      input int val);
    cmd <= '{op, sel, idx, 16'(val)};
    cmdValid <= 1;
    do @(negedge mclk); while (cmdReady !== 1'b1);
    @(posedge mclk);
    cmdValid <= 0;
    @(posedge mclk);
  endtask
  task automatic field();
    fieldStart <= 1;
    @(posedge mclk);
    fieldStart <= 0;
    @(posedge mclk);
  endtask
  // One pixel and one sample together, answers read a cycle later
  task automatic feed(input logic [1:0] c, input logic [2:0] g, input logic [9:0] ep,
                      input logic [23:0] es, input logic [2:0] ee);
    pixelComp <= c;
    pixelData <= 10'h3FF;
    sampleGroup <= g;
    pixelValid <= 1;
    sampleValid <= 1;
    @(posedge mclk);
    pixelValid <= 0;
    sampleValid <= 0;
    @(negedge mclk);
    check(pixelOutValid, 1);
    check(pixelOut, ep);
    check(sampleOut, es);
    check(emphasisBits, ee);
    @(posedge mclk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1;
    @(negedge mclk);
    check(blackLuma, 10'h040);
    @(posedge mclk);
    send(OP_LOGO_H, 1, 0, -1200);
    check(settings.logoH, 0);
    send(OP_MOVE_H, 1, 0, 7);
    send(OP_MOVE_V, 1, 0, -300);
    send(OP_MOVE_PERIOD, 1, 0, 2);
    send(OP_LEVEL, 2, 0, 3);
    field();
    check(settings.logoH, -1000);
    check(settings.blackLevel, LEVEL_BLACK);
    field();
    field();
    check(scrollV, -252);
    field();
    field();
    check(scrollV, -504);
    check(scrollH, 8);
    $display("settings and scroll test done");
    // The fitted flag is registered, so let it settle before a black-output command
    blackOutputOption <= 1;
    repeat (2) @(posedge mclk);
    send(OP_LEVEL, 2, 0, 3);
    send(OP_LUMA_ON, 1, 0, 0);
    send(OP_WORD_WIDTH_VIDEO, 1, 0, 8);
    send(OP_WORD_WIDTH_VIDEO, 2, 0, 8);
    send(OP_EMPHASIS, 1, 2, 1);
    send(OP_WORD_WIDTH, 1, 2, 20);
    send(OP_WORD_WIDTH, 1, 1, 24);
    field();
    feed(0, 1, 10'h040, 24'hFF_FFFF, 3'h4);
    feed(1, 2, 10'h3FC, 24'hFF_FFF0, 3'h6);
    check(blackLuma, 10'h3AC);
    $display("output path test done");
    stall <= 1;
    send(OP_LOGO_SAVE, 1, 0, 0);
    send(OP_TEXT_SAVE, 1, 0, 0);
    @(negedge mclk);
    check(cmdReady, 0);
    check(saveData.posH, -1000);
    stall <= 1'b0;
    repeat (4) @(posedge mclk);
    check(count, 2);
    check(last.textKind, 1);
    $display("save test done");
    send(OP_LOGO_ON, 1, 0, 1);
    send(OP_BLINK_ON, 1, 0, 1);
    field();
    repeat (40) @(negedge mclk) hid += !logoVisible;
    check(hid > 12 && hid < 28, 1);
    $display("blink test done");
    report_and_stop();
  end
endmodule

// file: test/video_overlay_sva.sv
// Port checker for the overlay control block
`timescale 1ns/10ps
module video_overlay_sva
  import video_overlay_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire cmd_type            cmd,
  input wire logic               cmdValid,
  input wire logic               cmdReady,
  input wire logic               fieldStart,
  input wire logic               pixelValid,
  input wire logic [1:0]         pixelComp,
  input wire settings_type       settings,
  input wire logic signed [11:0] scrollV,
  input wire logic               pixelOutValid,
  input wire logic [9:0]         pixelOut,
  input wire save_type           saveData,
  input wire logic               saveValid,
  input wire logic               saveReady
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Pixel path answers one cycle later with blanking and truncation applied
  pix_valid_a: assert property (pixelValid |=> pixelOutValid) else $error("pixel lost");
  luma_blank_a: assert property (pixelValid && pixelComp == 2'h0 && !settings.lumaOn
    |=> pixelOut == 10'h040) else $error("luma not blanked");
  eight_bit_a: assert property (pixelValid && settings.tenBit == 2'h0
    |=> pixelOut[1:0] == 2'h0) else $error("low bits kept");
  // Settings and scroll may only move at a field boundary, never mid-field
  field_commit_a: assert property ($changed(settings) |-> $past(fieldStart))
    else $error("settings moved mid-field");
  scroll_field_a: assert property ($changed(scrollV) |-> $past(fieldStart))
    else $error("scroll moved mid-field");
  move_quant_a: assert property (settings.moveH[1:0] == 2'h0)
    else $error("move not quantised");
  // Save records appear one cycle after the save command and wait for the store
  save_push_a: assert property (cmdValid && cmdReady && cmd.op == OP_LOGO_SAVE
    && cmd.sel == SEL_MAIN |=> saveValid) else $error("save not pushed");
  save_hold_a: assert property (saveValid && !saveReady |=> saveValid && $stable(saveData))
    else $error("save record dropped");
  full_cov: cover property (!cmdReady);
  scroll_cov: cover property ($changed(scrollV));
  blank_cov: cover property (pixelValid && !settings.lumaOn);
endmodule

bind video_overlay_control video_overlay_sva i_video_overlay_sva (.mclk, .rst_n, .cmd,
  .cmdValid, .cmdReady, .fieldStart, .pixelValid, .pixelComp, .settings, .scrollV,
  .pixelOutValid, .pixelOut, .saveData, .saveValid, .saveReady);

// file: verilog/video_overlay_control.sv
// Overlay, scroll, audio status and output setting control for the video generator
//
// Function
// - Audio group settings kept separately per group one-four and per output selector.
// - Emphasis choice only sets channel status bits; samples pass unfiltered.
// - Each group formats its samples at 20 or 24 bits as chosen.
// - Each group reports frame-locked, unlocked or asynchronous sample alignment.
// - Logo position spans minus 100 to 0 percent in tenth-percent steps.
// - Logo save emits current logo position to storage, no argument.
// - Horizontal scroll spans minus to plus 252 in four-sample steps.
// - Vertical scroll spans minus to plus 252 lines in one-line steps.
// - Scroll step applied once every N fields, N from 1 to 16.
// - Random scrolling can be switched on and off and read back.
// - One blink enable hides and shows logo, text and circle together.
// - Blink interval is half a second or one second.
// - Text overlay shows a programmable string, enabled on its own.
// - Text position spans 0 to 100 percent in one-percent steps.
// - Text save emits current string and position to storage.
// - Luma and both colour-difference components each switch on and off.
// - Each output selector carries 8-bit or 10-bit video as chosen.
// - EDH insertion enabled per output selector and readable back.
// - Audio/video timing measurement mode switches on main output.
// - Black output standard is 525/143, 525/270 or 625/270.
// - Black output level is black, 40, 50 or 100 percent field.
// - Black option presence reported; black settings accepted only when fitted.
// - Circle diameter 0 to 100 percent of height, gated by blink.
`timescale 1ns/10ps

module video_overlay_control
  import video_overlay_pkg::*;
#(
  parameter int BLINK_SHORT = BLINK_SHORT_CYCLES,
  parameter int BLINK_LONG  = BLINK_LONG_CYCLES
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire cmd_type      cmd,
  input  wire logic         cmdValid,
  output logic              cmdReady,
  input  wire logic         blackOutputOption,
  input  wire logic         fieldStart,
  input  wire logic         pixelValid,
  input  wire logic [1:0]   pixelComp,
  input  wire logic [9:0]   pixelData,
  input  wire logic         sampleValid,
  input  wire logic [1:0]   sampleSel,
  input  wire logic [2:0]   sampleGroup,
  input  wire logic [23:0]  sampleData,
  input  wire logic         saveReady,
  output settings_type      settings,
  output logic              blackFitted,
  output logic              logoVisible,
  output logic              textVisible,
  output logic              circleVisible,
  output logic signed [11:0] scrollH,
  output logic signed [11:0] scrollV,
  output logic              pixelOutValid,
  output logic [9:0]        pixelOut,
  output logic [9:0]        blackLuma,
  output logic              sampleOutValid,
  output logic [23:0]       sampleOut,
  output logic [2:0]        emphasisBits,
  output alignment_type     alignmentBits,
  output save_type          saveData,
  output logic              saveValid
);

  // Refuse blink counts the counter cannot hold or that would never toggle
  if (BLINK_SHORT < 1 || BLINK_LONG < 1 ||
      BLINK_SHORT >= (1 << BLINK_CNT_W) || BLINK_LONG >= (1 << BLINK_CNT_W)) begin : g_chk
    $error("Blink cycle counts out of range");
  end

  localparam logic [BLINK_CNT_W-1:0] SHORT_LAST = BLINK_CNT_W'(BLINK_SHORT - 1);
  localparam logic [BLINK_CNT_W-1:0] LONG_LAST  = BLINK_CNT_W'(BLINK_LONG - 1);

  state_type s;
  state_type next_s;

  // Saturate a command argument into its documented range
  function automatic logic signed [15:0] clampValue(input logic signed [15:0] v,
                                                    input int lo, input int hi);
    if (v < lo) begin
      return 16'(lo);
    end else if (v > hi) begin
      return 16'(hi);
    end
    return v;
  endfunction

  // Clamp to the scroll range and round toward zero onto a multiple of four
  function automatic logic signed [8:0] quantFour(input logic signed [15:0] v);
    logic signed [15:0] t;
    logic signed [15:0] m;
    t = clampValue(v, -MOVE_LIMIT, MOVE_LIMIT);
    m = (t < 0) ? -t : t;
    m = m & MASK_QUANT4;
    return 9'((t < 0) ? -m : m);
  endfunction

  function automatic logic [9:0] levelCode(input level_type l);
    case (l)
      LEVEL_GRAY:            return LUMA_40;
      HALF_LEVEL_FLAT_FIELD: return LUMA_50;
      LEVEL_WHITE:           return LUMA_100;
      default:               return BLANK_LUMA;
    endcase
  endfunction

  function automatic logic [2:0] emphasisCode(input emphasis_type e);
    case (e)
      EMPHASIS_CD:    return EMPH_BITS_CD;
      EMPHASIS_CCITT: return EMPH_BITS_CCIT;
      default:        return EMPH_BITS_NONE;
    endcase
  endfunction

  // Next-state logic for the whole block
  always_comb begin
    logic                     take;
    logic                     mainOk;
    logic                     selOk;
    logic                     blackOk;
    logic                     grpOk;
    logic                     si;
    logic [1:0]               gi;
    logic                     pop;
    logic                     push;
    save_type                 rec;
    logic signed [15:0]       lv;
    logic signed [8:0]        stepH;
    logic signed [8:0]        stepV;
    logic [BLINK_CNT_W-1:0]   last;
    logic                     compOn;
    logic [9:0]               pix;
    logic [1:0]               sg;
    logic                     ss;
    audio_group_type          ag;
    take    = 1'b0;
    mainOk  = 1'b0;
    selOk   = 1'b0;
    blackOk = 1'b0;
    grpOk   = 1'b0;
    si      = 1'b0;
    gi      = 2'h0;
    pop     = 1'b0;
    push    = 1'b0;
    rec     = '0;
    lv      = '0;
    stepH   = '0;
    stepV   = '0;
    last    = '0;
    compOn  = 1'b0;
    pix     = '0;
    sg      = 2'h0;
    ss      = 1'b0;
    ag      = '0;
    next_s  = s;

    next_s.fitted = blackOutputOption;

    // Decode one command into the pending copy of the settings
    take    = cmdValid && s.cmdReady;
    mainOk  = (cmd.sel == SEL_MAIN);
    blackOk = (cmd.sel == SEL_BLACK) && s.fitted;
    selOk   = mainOk || blackOk;
    si      = (cmd.sel == SEL_BLACK);
    grpOk   = (cmd.index >= 4'h1) && (cmd.index <= 4'h4);
    gi      = 2'(cmd.index - 4'h1);
    lv      = cmd.value;
    if (take) begin
      case (cmd.op)
        OP_GROUP_ON: begin
          if (selOk && grpOk) next_s.pending.embeddedAudio[si][gi].on = lv[0];
        end
        OP_EMPHASIS: begin
          if (selOk && grpOk && lv <= 16'sh0002) begin
            next_s.pending.embeddedAudio[si][gi].emphasis = emphasis_type'(lv[1:0]);
          end
        end
        OP_WORD_WIDTH: begin
          if (selOk && grpOk && (lv == 16'sd20 || lv == 16'sd24)) begin
            next_s.pending.embeddedAudio[si][gi].wide24 = (lv == 16'sd24);
          end
        end
        OP_ALIGNMENT: begin
          if (selOk && grpOk && lv <= 16'sh0002) begin
            next_s.pending.embeddedAudio[si][gi].alignment = alignment_type'(lv[1:0]);
          end
        end
        OP_LOGO_ON:   if (mainOk) next_s.pending.logoOn = lv[0];
        OP_LOGO_H: begin
          if (mainOk) next_s.pending.logoH = 11'(clampValue(lv, LOGO_POS_MIN, LOGO_POS_MAX));
        end
        OP_LOGO_V: begin
          if (mainOk) next_s.pending.logoV = 11'(clampValue(lv, LOGO_POS_MIN, LOGO_POS_MAX));
        end
        OP_LOGO_SAVE: begin
          if (mainOk) begin
            push     = 1'b1;
            rec.posH = s.active.logoH;
            rec.posV = s.active.logoV;
          end
        end
        OP_MOVE_H:  if (mainOk) next_s.pending.moveH = quantFour(lv);
        OP_MOVE_V: begin
          if (mainOk) next_s.pending.moveV = 9'(clampValue(lv, -MOVE_LIMIT, MOVE_LIMIT));
        end
        OP_MOVE_PERIOD: begin
          if (mainOk) next_s.pending.periodM1 =
            4'(clampValue(lv, PERIOD_MIN, PERIOD_MAX) - 16'sd1);
        end
        OP_RANDOM:   if (mainOk) next_s.pending.randomOn = lv[0];
        OP_BLINK_ON: if (mainOk) next_s.pending.blinkOn = lv[0];
        OP_BLINK_PERIOD: begin
          // Argument in tenths of a second; any other figure is ignored
          if (mainOk && (lv == BLINK_CODE_SHORT || lv == BLINK_CODE_LONG)) begin
            next_s.pending.blinkLong = (lv == BLINK_CODE_LONG);
          end
        end
        OP_TEXT_ON: if (mainOk) next_s.pending.textOn = lv[0];
        OP_TEXT_CHAR: begin
          if (mainOk) next_s.pending.textData[cmd.index*8 +: 8] = lv[7:0];
        end
        OP_TEXT_H: if (mainOk) next_s.pending.textH = 7'(clampValue(lv, PCT_MIN, PCT_MAX));
        OP_TEXT_V: if (mainOk) next_s.pending.textV = 7'(clampValue(lv, PCT_MIN, PCT_MAX));
        OP_TEXT_SAVE: begin
          if (mainOk) begin
            push         = 1'b1;
            rec.textKind = 1'b1;
            rec.posH     = 11'(s.active.textH);
            rec.posV     = 11'(s.active.textV);
            rec.text     = s.active.textData;
          end
        end
        OP_LUMA_ON: if (mainOk) next_s.pending.lumaOn = lv[0];
        OP_CB_ON:   if (mainOk) next_s.pending.cbOn = lv[0];
        OP_CR_ON:   if (mainOk) next_s.pending.crOn = lv[0];
        OP_WORD_WIDTH_VIDEO: begin
          if (selOk && (lv == 16'sd8 || lv == 16'sd10)) begin
            next_s.pending.tenBit[si] = (lv == 16'sd10);
          end
        end
        OP_EDH:     if (selOk) next_s.pending.edhOn[si] = lv[0];
        OP_AV_SYNC: if (mainOk) next_s.pending.avSyncMeasureMode = lv[0];
        OP_STANDARD: begin
          if (blackOk && lv <= 16'sh0002) next_s.pending.blackStd = standard_type'(lv[1:0]);
        end
        OP_LEVEL: begin
          if (blackOk && lv <= 16'sh0003) next_s.pending.blackLevel = level_type'(lv[1:0]);
        end
        OP_CIRCLE_ON: if (mainOk) next_s.pending.circleOn = lv[0];
        OP_CIRCLE_DIA: begin
          if (mainOk) next_s.pending.circleDia = 7'(clampValue(lv, PCT_MIN, PCT_MAX));
        end
        default: begin
        end
      endcase
    end

    // Two-entry save buffer; a full buffer stalls every command, not only saves
    pop = s.saveValid && saveReady;
    if (pop) begin
      next_s.saveBuf[0] = s.saveBuf[1];
      next_s.saveBuf[1] = '0;
    end
    next_s.saveCount = s.saveCount - 2'(pop);
    if (push) begin
      next_s.saveBuf[next_s.saveCount[0]] = rec;
      next_s.saveCount = next_s.saveCount + 2'h1;
    end
    next_s.saveValid = (next_s.saveCount != 2'h0);
    next_s.cmdReady  = (next_s.saveCount != 2'h2);

    // Field boundary: commit pending settings and advance the scroll
    if (fieldStart) begin
      next_s.active = next_s.pending;
      next_s.lfsr   = {s.lfsr[14:0], ^(s.lfsr & LFSR_TAPS)};
      if (s.fieldCnt >= s.active.periodM1) begin
        next_s.fieldCnt = 4'h0;
        if (s.active.randomOn) begin
          // Random steps stay inside the same ranges and quantisation
          stepH = quantFour(16'(signed'({1'b0, s.lfsr[7:0]})) - 16'sd128);
          stepV = 9'(clampValue(16'(signed'({1'b0, s.lfsr[15:8]})) - 16'sd128,
                                -MOVE_LIMIT, MOVE_LIMIT));
        end else begin
          stepH = s.active.moveH;
          stepV = s.active.moveV;
        end
        next_s.scrollH = s.scrollH + 12'(stepH);
        next_s.scrollV = s.scrollV + 12'(stepV);
      end else begin
        next_s.fieldCnt = s.fieldCnt + 4'h1;
      end
    end

    // Blink timer; restarts in the shown phase whenever blinking is off
    last = s.active.blinkLong ? LONG_LAST : SHORT_LAST;
    if (!s.active.blinkOn) begin
      next_s.blinkCnt  = '0;
      next_s.blinkShow = 1'b1;
    end else if (s.blinkCnt >= last) begin
      next_s.blinkCnt  = '0;
      next_s.blinkShow = !s.blinkShow;
    end else begin
      next_s.blinkCnt = s.blinkCnt + 1'b1;
    end
    next_s.logoVis   = s.active.logoOn && s.blinkShow;
    next_s.textVis   = s.active.textOn && s.blinkShow;
    next_s.circleVis = s.active.circleOn && s.blinkShow;

    // Main video path: component gating, then 8-bit truncation if chosen
    case (pixelComp)
      2'h0:    compOn = s.active.lumaOn;
      2'h1:    compOn = s.active.cbOn;
      2'h2:    compOn = s.active.crOn;
      default: compOn = 1'b0;
    endcase
    if (!compOn) begin
      pix = (pixelComp == 2'h0) ? BLANK_LUMA : BLANK_CHROMA;
    end else begin
      pix = pixelData;
    end
    next_s.pixValid = pixelValid;
    next_s.pixOut   = s.active.tenBit[0] ? pix : (pix & MASK_8BIT);
    next_s.blackLuma = !s.fitted ? BLANK_LUMA :
                       (s.active.tenBit[1] ? levelCode(s.active.blackLevel) :
                        (levelCode(s.active.blackLevel) & MASK_8BIT));

    // Audio path: width formatting and status bits; samples never filtered
    ss = (sampleSel == SEL_BLACK);
    sg = 2'(sampleGroup - 3'h1);
    ag = s.active.embeddedAudio[ss][sg];
    next_s.smpValid  = sampleValid && ag.on &&
                       (sampleGroup >= 3'h1) && (sampleGroup <= 3'h4) &&
                       (!ss || s.fitted);
    next_s.smpOut    = ag.wide24 ? sampleData : (sampleData & MASK_20BIT);
    next_s.emphBits  = emphasisCode(ag.emphasis);
    next_s.alignBits = ag.alignment;

    // Synchronous reset
    if (!rst_n) begin
      next_s           = '0;
      next_s.pending   = settingsReset();
      next_s.active    = settingsReset();
      next_s.blinkShow = 1'b1;
      next_s.lfsr      = LFSR_SEED;
      next_s.cmdReady  = 1'b1;
      next_s.blackLuma = BLANK_LUMA;
      next_s.emphBits  = EMPH_BITS_NONE;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    s <= next_s;
  end

  // Outputs straight from the state flops
  assign cmdReady       = s.cmdReady;
  assign settings       = s.active;
  assign blackFitted    = s.fitted;
  assign logoVisible    = s.logoVis;
  assign textVisible    = s.textVis;
  assign circleVisible  = s.circleVis;
  assign scrollH        = s.scrollH;
  assign scrollV        = s.scrollV;
  assign pixelOutValid  = s.pixValid;
  assign pixelOut       = s.pixOut;
  assign blackLuma      = s.blackLuma;
  assign sampleOutValid = s.smpValid;
  assign sampleOut      = s.smpOut;
  assign emphasisBits   = s.emphBits;
  assign alignmentBits  = s.alignBits;
  assign saveData       = s.saveBuf[0];
  assign saveValid      = s.saveValid;

endmodule

// file: verilog/video_overlay_pkg.sv
// Constants, codes and carrier types for the video output overlay control block
package video_overlay_pkg;

  localparam int GROUP_COUNT = 4;
  localparam int SEL_COUNT   = 2;
  localparam logic [1:0] SEL_MAIN  = 2'h1;
  localparam logic [1:0] SEL_BLACK = 2'h2;
  localparam int TEXT_CHARS  = 16;

  // Timing: times in their own units, cycle counts derived from the clock rate
  localparam int CLOCK_KHZ          = 40000;
  localparam int BLINK_SHORT_MS     = 500;
  localparam int BLINK_LONG_MS      = 1000;
  localparam int BLINK_SHORT_CYCLES = BLINK_SHORT_MS * CLOCK_KHZ;
  localparam int BLINK_LONG_CYCLES  = BLINK_LONG_MS * CLOCK_KHZ;
  localparam int BLINK_CNT_W        = 26;
  localparam int BLINK_CODE_SHORT   = 5;
  localparam int BLINK_CODE_LONG    = 10;

  // Setting ranges
  localparam int LOGO_POS_MIN = -1000;
  localparam int LOGO_POS_MAX = 0;
  localparam int PCT_MIN      = 0;
  localparam int PCT_MAX      = 100;
  localparam int MOVE_LIMIT   = 252;
  localparam int PERIOD_MIN   = 1;
  localparam int PERIOD_MAX   = 16;

  // Video and audio codes
  localparam logic [9:0]  BLANK_LUMA     = 10'h040;
  localparam logic [9:0]  BLANK_CHROMA   = 10'h200;
  localparam logic [9:0]  LUMA_40        = 10'h19E;
  localparam logic [9:0]  LUMA_50        = 10'h1F6;
  localparam logic [9:0]  LUMA_100       = 10'h3AC;
  localparam logic [9:0]  MASK_8BIT      = 10'h3FC;
  localparam logic [15:0] MASK_QUANT4    = 16'hFFFC;
  localparam logic [23:0] MASK_20BIT     = 24'hFF_FFF0;
  localparam logic [2:0]  EMPH_BITS_NONE = 3'h4;
  localparam logic [2:0]  EMPH_BITS_CD   = 3'h6;
  localparam logic [2:0]  EMPH_BITS_CCIT = 3'h7;
  localparam logic [15:0] LFSR_SEED      = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS      = 16'hB400;

  typedef enum logic [1:0] {EMPHASIS_OFF = 2'b00, EMPHASIS_CD = 2'b01,
                            EMPHASIS_CCITT = 2'b10} emphasis_type;
  typedef enum logic [1:0] {FRAME_ALIGNMENT = 2'b00, UNLOCKED_ALIGNMENT = 2'b01,
                            ASYNCHRONOUS_ALIGNMENT = 2'b10} alignment_type;
  typedef enum logic [1:0] {STD_525_143 = 2'b00, STD_525_270 = 2'b01,
                            STD_625_270 = 2'b10} standard_type;
  typedef enum logic [1:0] {LEVEL_BLACK = 2'b00, LEVEL_GRAY = 2'b01,
                            HALF_LEVEL_FLAT_FIELD = 2'b10, LEVEL_WHITE = 2'b11} level_type;
  typedef enum logic [4:0] {
    OP_NONE = 5'b00000, OP_GROUP_ON = 5'b00001, OP_EMPHASIS = 5'b00010,
    OP_WORD_WIDTH = 5'b00011, OP_ALIGNMENT = 5'b00100, OP_LOGO_ON = 5'b00101,
    OP_LOGO_H = 5'b00110, OP_LOGO_V = 5'b00111, OP_LOGO_SAVE = 5'b01000,
    OP_MOVE_H = 5'b01001, OP_MOVE_V = 5'b01010, OP_MOVE_PERIOD = 5'b01011,
    OP_RANDOM = 5'b01100, OP_BLINK_ON = 5'b01101, OP_BLINK_PERIOD = 5'b01110,
    OP_TEXT_ON = 5'b01111, OP_TEXT_CHAR = 5'b10000, OP_TEXT_H = 5'b10001,
    OP_TEXT_V = 5'b10010, OP_TEXT_SAVE = 5'b10011, OP_LUMA_ON = 5'b10100,
    OP_CB_ON = 5'b10101, OP_CR_ON = 5'b10110, OP_WORD_WIDTH_VIDEO = 5'b10111,
    OP_EDH = 5'b11000, OP_AV_SYNC = 5'b11001, OP_STANDARD = 5'b11010,
    OP_LEVEL = 5'b11011, OP_CIRCLE_ON = 5'b11100, OP_CIRCLE_DIA = 5'b11101
  } op_type;

  typedef struct packed {
    op_type             op;
    logic [1:0]         sel;
    logic [3:0]         index;
    logic signed [15:0] value;
  } cmd_type;

  typedef struct packed {
    logic          on;
    emphasis_type  emphasis;
    logic          wide24;
    alignment_type alignment;
  } audio_group_type;

  typedef struct packed {
    audio_group_type [SEL_COUNT-1:0][GROUP_COUNT-1:0] embeddedAudio;
    logic                      logoOn;
    logic signed [10:0]        logoH;
    logic signed [10:0]        logoV;
    logic                      textOn;
    logic [6:0]                textH;
    logic [6:0]                textV;
    logic [TEXT_CHARS*8-1:0]   textData;
    logic                      circleOn;
    logic [6:0]                circleDia;
    logic signed [8:0]         moveH;
    logic signed [8:0]         moveV;
    logic [3:0]                periodM1;
    logic                      randomOn;
    logic                      blinkOn;
    logic                      blinkLong;
    logic                      lumaOn;
    logic                      cbOn;
    logic                      crOn;
    logic [SEL_COUNT-1:0]      tenBit;
    logic [SEL_COUNT-1:0]      edhOn;
    logic                      avSyncMeasureMode;
    standard_type              blackStd;
    level_type                 blackLevel;
  } settings_type;

  typedef struct packed {
    logic                    textKind;
    logic signed [10:0]      posH;
    logic signed [10:0]      posV;
    logic [TEXT_CHARS*8-1:0] text;
  } save_type;

  typedef struct packed {
    settings_type             pending;
    settings_type             active;
    logic [BLINK_CNT_W-1:0]   blinkCnt;
    logic                     blinkShow;
    logic [3:0]               fieldCnt;
    logic [15:0]              lfsr;
    logic signed [11:0]       scrollH;
    logic signed [11:0]       scrollV;
    logic                     logoVis;
    logic                     textVis;
    logic                     circleVis;
    save_type [1:0]           saveBuf;
    logic [1:0]               saveCount;
    logic                     saveValid;
    logic                     cmdReady;
    logic                     fitted;
    logic                     pixValid;
    logic [9:0]               pixOut;
    logic [9:0]               blackLuma;
    logic                     smpValid;
    logic [23:0]              smpOut;
    logic [2:0]               emphBits;
    alignment_type            alignBits;
  } state_type;

  function automatic settings_type settingsReset();
    settings_type r;
    r = '0;
    for (int i = 0; i < SEL_COUNT; i++) begin
      for (int g = 0; g < GROUP_COUNT; g++) begin
        r.embeddedAudio[i][g].on = 1'b1;
      end
    end
    r.lumaOn   = 1'b1;
    r.cbOn     = 1'b1;
    r.crOn     = 1'b1;
    r.tenBit   = 2'h3;
    r.blackStd = STD_525_270;
    return r;
  endfunction

endpackage
